// >>> rsq_pkg.sv
// constants, modes and field layouts for the reset sequencer
package rsq_pkg;
	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	localparam logic [PC_W-1:0] RESET_VECTOR = 21'h000000;
	localparam logic [PC_W-1:0] HIGH_VECTOR = 21'h000008;
	localparam logic [PC_W-1:0] LOW_VECTOR = 21'h000018;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

	localparam logic [ADDR_W-1:0] OFF_CAUSE = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_STACK = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_TOS = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_SCRATCH = 12'h014;

	localparam int CAUSE_BROWN_BIT = 0;
	localparam int CAUSE_POR_BIT = 1;
	localparam int CAUSE_SLEEP_BIT = 2;
	localparam int CAUSE_WDOG_BIT = 3;
	localparam int CAUSE_OPC_BIT = 4;
	localparam int CAUSE_IPEN_BIT = 7;
	localparam int STACK_UNF_BIT = 6;
	localparam int STACK_FULL_BIT = 7;
	localparam int CTRL_STKRST_BIT = 0;
	localparam int CTRL_HIE_BIT = 1;
	localparam int CTRL_LIE_BIT = 2;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_CORE_BIT = 1;
	localparam int STAT_COUNT_LSB = 16;

	localparam real SLOW_OSC_PERIOD_US = 32.0;
	localparam real DELAY_NOMINAL_MS = 65.6;
	localparam real CLK_PERIOD_NS = 10.0;
	localparam int DELAY_WIDTH = 11;
	localparam int DELAY_TICKS = 2048;

	typedef enum logic [1:0] {
		MODE_FULL,
		MODE_RUN_LP,
		MODE_IDLE,
		MODE_SLEEP
	} rsq_mode_e;

	typedef struct packed {
		logic reset_opcode_flag;
		logic watchdog_expiry_flag;
		logic sleep_entry_flag;
		logic power_on_flag;
		logic brownout_event_flag;
	} rsq_cause_s;

	typedef struct packed {
		logic stack_full_flag;
		logic stack_underflow_flag;
		logic [SP_W-1:0] ptr;
	} rsq_stack_s;

	localparam rsq_cause_s CAUSE_ON_POR = 5'h1C;
	localparam rsq_stack_s STACK_ON_POR = 7'h00;
	localparam logic [DATA_W-1:0] SCRATCH_RESET = 32'h00000000;
endpackage : rsq_pkg

// >>> rsq_osc_edge.sv
// rising-edge strobe of the internal slow oscillator
`timescale 1ns/1ps
`default_nettype none
module rsq_osc_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic internal_slow_oscillator,
	output logic osc_rise
);
	logic osc_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_prev <= 1'h0;
			osc_rise <= 1'h0;
		end else if (ce) begin
			osc_prev <= internal_slow_oscillator;
			osc_rise <= internal_slow_oscillator & ~osc_prev;
		end
	end
endmodule : rsq_osc_edge
`default_nettype wire

// >>> rsq_power_up_delay_timer.sv
// power-up delay timer counting slow oscillator periods
`timescale 1ns/1ps
`default_nettype none
module rsq_delay_timer #(
	parameter int WIDTH = rsq_pkg::DELAY_WIDTH,
	parameter int TICKS = rsq_pkg::DELAY_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic restart,
	input wire logic osc_rise,
	output logic done,
	output logic [WIDTH-1:0] count
);
	localparam logic [WIDTH-1:0] LAST = WIDTH'(TICKS - 1);

	if (TICKS < 1 || TICKS > (2 ** WIDTH)) begin : g_bad_ticks
		$error("tick count does not fit the counter width");
	end

	// gated by ce: once released the timer runs on each oscillator rise and stops at done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			done <= 1'h0;
		end else if (ce) begin
			if (restart) begin
				count <= '0;
				done <= 1'h0;
			end else if (osc_rise && !done) begin
				if (count == LAST) begin
					done <= 1'h1;
				end else begin
					count <= count + WIDTH'(1);
				end
			end
		end
	end

	a_delay_restart_clear: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && restart) |=> (count == '0 && !done))
		else $error("timer not cleared by restart");

	a_delay_full_count: assert property (@(posedge pclk)
		disable iff (!presetn)
		$rose(done) |-> ($past(count) == LAST && $past(osc_rise)))
		else $error("timer expired before full count");
endmodule : rsq_delay_timer
`default_nettype wire

// >>> rsq_top.sv
// reset sequencer: power-up delay, cause flags, vector select, apb regs
//
// How it works
// - eleven-bit timer counts 2048 slow oscillator periods
// - core held in reset while timer counts
// - timer starts only after power-on pulse ends
// - pin released after expiry starts core immediately
// - power-on loads zero vector, sets default flags
// - pin reset in low-power run sets timeout flag
// - pin reset asleep sets timeout, clears power-down
// - watchdog expiry while running clears timeout flag
// - pin reset at full power keeps all flags
// - enabled overflow resets and sets full flag
// - underflow sets flag, resets only when enabled
// - watchdog wake resumes at next instruction, clears flags
// - interrupt wake resumes next instruction, clears power-down
// - enabled interrupt wake loads interrupt vector
// - enabled interrupt wake pushes pc, bumps pointer
// - watchdog wake leaves other registers untouched
// - undefined registers survive every non-power-on reset
// - brown-out holds reset for delay, restarts timer
// - external reset pin never driven by device
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rsq_top #(
	parameter int DELAY_WIDTH = rsq_pkg::DELAY_WIDTH,
	parameter int DELAY_TICKS = rsq_pkg::DELAY_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rsq_pkg::ADDR_W-1:0] paddr,
	input wire logic [rsq_pkg::DATA_W-1:0] pwdata,
	output logic [rsq_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic por_active,
	input wire logic brownout_active,
	input wire logic external_reset_pin_n,
	output logic external_reset_pin_out,
	output logic external_reset_pin_oe,
	input wire logic internal_slow_oscillator,
	input wire logic watchdog_timer_expired,
	input wire logic stack_overflow,
	input wire logic stack_underflow,
	input wire logic reset_opcode,
	input wire logic sleep_exec,
	input wire logic clrwdt_exec,
	input wire logic irq_wake,
	input wire logic irq_high_priority,
	input wire rsq_pkg::rsq_mode_e power_mode,
	input wire logic [rsq_pkg::PC_W-1:0] current_pc,
	output logic core_reset,
	output logic pc_load,
	output logic [rsq_pkg::PC_W-1:0] pc_value,
	output logic [4:0] stack_top_upper,
	output logic [7:0] stack_top_high,
	output logic [7:0] stack_top_low,
	output logic [rsq_pkg::SP_W-1:0] stack_pointer
);
	typedef enum logic [1:0] {
		ST_POR,
		ST_DELAY,
		ST_HOLD_PIN,
		ST_RUN
	} rsq_seq_e;

	rsq_seq_e st;
	rsq_seq_e next_st;
	rsq_pkg::rsq_cause_s reset_cause_reg;
	rsq_pkg::rsq_stack_s stack_pointer_reg;
	logic [rsq_pkg::PC_W-1:0] tos;
	logic ipen;
	logic stack_error_reset_enable;
	logic high_priority_global_irq_enable;
	logic low_priority_global_irq_enable;
	logic [rsq_pkg::DATA_W-1:0] scratch;
	logic osc_rise;
	logic delay_done;
	logic [DELAY_WIDTH-1:0] delay_count;
	logic supply_low;
	logic live;
	logic run_ok;
	logic asleep;
	logic pin_evt;
	logic wdog_rst;
	logic wdog_wake;
	logic ovf_ev;
	logic unf_ev;
	logic stk_rst;
	logic opc_rst;
	logic int_rst;
	logic irq_ev;
	logic irq_take;
	logic any_reset;
	logic wr_en;
	logic [rsq_pkg::DATA_W-1:0] rd_word;

	function automatic logic hit(input logic [rsq_pkg::ADDR_W-1:0] a,
		input logic [rsq_pkg::ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	rsq_osc_edge u_osc_edge (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.internal_slow_oscillator(internal_slow_oscillator),
		.osc_rise(osc_rise)
	);

	// the count must fit the status word above its low flags
	if (DELAY_WIDTH < 1 ||
		DELAY_WIDTH > rsq_pkg::DATA_W - rsq_pkg::STAT_COUNT_LSB)
	begin : g_bad_width
		$error("timer width does not fit the status word");
	end

	rsq_delay_timer #(
		.WIDTH(DELAY_WIDTH),
		.TICKS(DELAY_TICKS)
	) u_delay (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.restart(supply_low || st == ST_POR),
		.osc_rise(osc_rise),
		.done(delay_done),
		.count(delay_count)
	);

	assign supply_low = por_active | brownout_active;
	// the pin is input only: internal resets never pull it
	assign external_reset_pin_out = 1'h0;
	assign external_reset_pin_oe = 1'h0;

	always_comb begin
		next_st = st;
		case (st)
		ST_POR: begin
			if (!supply_low) begin
				next_st = ST_DELAY;
			end
		end
		ST_DELAY: begin
			if (supply_low) begin
				next_st = ST_POR;
			end else if (delay_done) begin
				next_st = external_reset_pin_n ? ST_RUN : ST_HOLD_PIN;
			end
		end
		ST_HOLD_PIN: begin
			if (supply_low) begin
				next_st = ST_POR;
			end else if (external_reset_pin_n) begin
				next_st = ST_RUN;
			end
		end
		ST_RUN: begin
			if (supply_low) begin
				next_st = ST_POR;
			end else if (!external_reset_pin_n) begin
				next_st = ST_HOLD_PIN;
			end
		end
		default: next_st = ST_POR;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_POR;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// events only count while the core actually runs
	assign live = ce && st == ST_RUN && !supply_low;
	assign pin_evt = live && !external_reset_pin_n;
	assign run_ok = live && external_reset_pin_n;
	assign asleep = power_mode == rsq_pkg::MODE_IDLE ||
		power_mode == rsq_pkg::MODE_SLEEP;
	assign wdog_rst = run_ok && watchdog_timer_expired && !asleep;
	assign ovf_ev = run_ok && stack_overflow;
	assign unf_ev = run_ok && stack_underflow;
	assign stk_rst = stack_error_reset_enable && (ovf_ev || unf_ev);
	assign opc_rst = run_ok && reset_opcode;
	assign int_rst = wdog_rst || stk_rst || opc_rst;
	assign wdog_wake = run_ok && watchdog_timer_expired && asleep &&
		!int_rst;
	assign irq_ev = run_ok && irq_wake && power_mode != rsq_pkg::MODE_FULL &&
		!int_rst && !wdog_wake;
	assign irq_take = irq_ev && (high_priority_global_irq_enable ||
		low_priority_global_irq_enable);
	assign any_reset = st != ST_RUN || int_rst || pin_evt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset <= 1'h1;
		end else if (ce) begin
			core_reset <= next_st != ST_RUN || int_rst;
		end
	end

	assign pready = ce;
	assign wr_en = psel && penable && pwrite && ce;
	assign pslverr = psel && penable && !(hit(paddr, rsq_pkg::OFF_CAUSE) ||
		hit(paddr, rsq_pkg::OFF_STACK) || hit(paddr, rsq_pkg::OFF_TOS) ||
		hit(paddr, rsq_pkg::OFF_CTRL) || hit(paddr, rsq_pkg::OFF_STATUS) ||
		hit(paddr, rsq_pkg::OFF_SCRATCH));

	// hardware events are applied after software writes so the hardware update wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_cause_reg <= rsq_pkg::CAUSE_ON_POR;
		end else if (ce) begin
			if (por_active) begin
				reset_cause_reg <= rsq_pkg::CAUSE_ON_POR;
			end else if (brownout_active) begin
				reset_cause_reg.reset_opcode_flag <= 1'h1;
				reset_cause_reg.watchdog_expiry_flag <= 1'h1;
				reset_cause_reg.sleep_entry_flag <= 1'h1;
				reset_cause_reg.brownout_event_flag <= 1'h0;
			end else begin
				if (wr_en && hit(paddr, rsq_pkg::OFF_CAUSE)) begin
					reset_cause_reg.reset_opcode_flag <=
						pwdata[rsq_pkg::CAUSE_OPC_BIT];
					reset_cause_reg.power_on_flag <=
						pwdata[rsq_pkg::CAUSE_POR_BIT];
					reset_cause_reg.brownout_event_flag <=
						pwdata[rsq_pkg::CAUSE_BROWN_BIT];
				end
				if (opc_rst) begin
					reset_cause_reg.reset_opcode_flag <= 1'h0;
				end
				if (sleep_exec && run_ok) begin
					reset_cause_reg.watchdog_expiry_flag <= 1'h1;
					reset_cause_reg.sleep_entry_flag <= 1'h0;
				end
				if (clrwdt_exec && run_ok) begin
					reset_cause_reg.watchdog_expiry_flag <= 1'h1;
					reset_cause_reg.sleep_entry_flag <= 1'h1;
				end
				// full-power pin reset changes no flag at all
				if (pin_evt && power_mode == rsq_pkg::MODE_RUN_LP) begin
					reset_cause_reg.watchdog_expiry_flag <= 1'h1;
				end
				if (pin_evt && asleep) begin
					reset_cause_reg.watchdog_expiry_flag <= 1'h1;
					reset_cause_reg.sleep_entry_flag <= 1'h0;
				end
				if (irq_ev) begin
					reset_cause_reg.sleep_entry_flag <= 1'h0;
				end
				if (wdog_wake) begin
					reset_cause_reg.watchdog_expiry_flag <= 1'h0;
					reset_cause_reg.sleep_entry_flag <= 1'h0;
				end
				if (wdog_rst) begin
					reset_cause_reg.watchdog_expiry_flag <= 1'h0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_pointer_reg <= rsq_pkg::STACK_ON_POR;
			tos <= rsq_pkg::RESET_VECTOR;
		end else if (ce) begin
			if (por_active) begin
				stack_pointer_reg <= rsq_pkg::STACK_ON_POR;
				tos <= rsq_pkg::RESET_VECTOR;
			end else begin
				if (wr_en && hit(paddr, rsq_pkg::OFF_STACK)) begin
					stack_pointer_reg.stack_full_flag <=
						pwdata[rsq_pkg::STACK_FULL_BIT];
					stack_pointer_reg.stack_underflow_flag <=
						pwdata[rsq_pkg::STACK_UNF_BIT];
					stack_pointer_reg.ptr <= pwdata[rsq_pkg::SP_W-1:0];
				end
				if (wr_en && hit(paddr, rsq_pkg::OFF_TOS)) begin
					tos <= pwdata[rsq_pkg::PC_W-1:0];
				end
				if (any_reset || brownout_active) begin
					stack_pointer_reg.ptr <= '0;
					tos <= rsq_pkg::RESET_VECTOR;
				end else if (irq_take) begin
					tos <= current_pc;
					stack_pointer_reg.ptr <= stack_pointer_reg.ptr +
						rsq_pkg::SP_W'(1);
				end
				if (ovf_ev) begin
					stack_pointer_reg.stack_full_flag <= 1'h1;
				end
				if (unf_ev) begin
					stack_pointer_reg.stack_underflow_flag <= 1'h1;
				end
			end
		end
	end

	// wake-ups only touch flags, pc and stack; everything else is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ipen <= 1'h0;
			stack_error_reset_enable <= 1'h0;
			high_priority_global_irq_enable <= 1'h0;
			low_priority_global_irq_enable <= 1'h0;
		end else if (ce) begin
			if (wr_en && hit(paddr, rsq_pkg::OFF_CTRL)) begin
				stack_error_reset_enable <= pwdata[rsq_pkg::CTRL_STKRST_BIT];
				high_priority_global_irq_enable <=
					pwdata[rsq_pkg::CTRL_HIE_BIT];
				low_priority_global_irq_enable <=
					pwdata[rsq_pkg::CTRL_LIE_BIT];
			end
			if (wr_en && hit(paddr, rsq_pkg::OFF_CAUSE)) begin
				ipen <= pwdata[rsq_pkg::CAUSE_IPEN_BIT];
			end
			if (any_reset) begin
				ipen <= 1'h0;
				high_priority_global_irq_enable <= 1'h0;
				low_priority_global_irq_enable <= 1'h0;
			end
		end
	end

	// scratch has no reset state of its own, so only presetn clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scratch <= rsq_pkg::SCRATCH_RESET;
		end else if (ce && wr_en && hit(paddr, rsq_pkg::OFF_SCRATCH)) begin
			scratch <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_load <= 1'h0;
			pc_value <= rsq_pkg::RESET_VECTOR;
		end else if (ce) begin
			pc_load <= 1'h0;
			if (any_reset || supply_low) begin
				pc_load <= 1'h1;
				pc_value <= rsq_pkg::RESET_VECTOR;
			end else if (wdog_wake || (irq_ev && !irq_take)) begin
				pc_load <= 1'h1;
				pc_value <= current_pc + rsq_pkg::PC_STEP;
			end else if (irq_take) begin
				pc_load <= 1'h1;
				pc_value <= irq_high_priority ? rsq_pkg::HIGH_VECTOR :
					rsq_pkg::LOW_VECTOR;
			end
		end
	end

	always_comb begin
		rd_word = '0;
		if (hit(paddr, rsq_pkg::OFF_CAUSE)) begin
			rd_word[rsq_pkg::CAUSE_IPEN_BIT] = ipen;
			rd_word[rsq_pkg::CAUSE_OPC_BIT:0] = reset_cause_reg;
		end else if (hit(paddr, rsq_pkg::OFF_STACK)) begin
			rd_word[rsq_pkg::STACK_FULL_BIT] =
				stack_pointer_reg.stack_full_flag;
			rd_word[rsq_pkg::STACK_UNF_BIT] =
				stack_pointer_reg.stack_underflow_flag;
			rd_word[rsq_pkg::SP_W-1:0] = stack_pointer_reg.ptr;
		end else if (hit(paddr, rsq_pkg::OFF_TOS)) begin
			rd_word[rsq_pkg::PC_W-1:0] = tos;
		end else if (hit(paddr, rsq_pkg::OFF_CTRL)) begin
			rd_word[rsq_pkg::CTRL_STKRST_BIT] = stack_error_reset_enable;
			rd_word[rsq_pkg::CTRL_HIE_BIT] = high_priority_global_irq_enable;
			rd_word[rsq_pkg::CTRL_LIE_BIT] = low_priority_global_irq_enable;
		end else if (hit(paddr, rsq_pkg::OFF_STATUS)) begin
			rd_word[rsq_pkg::STAT_DONE_BIT] = delay_done;
			rd_word[rsq_pkg::STAT_CORE_BIT] = core_reset;
			rd_word[rsq_pkg::STAT_COUNT_LSB +: DELAY_WIDTH] = delay_count;
		end else if (hit(paddr, rsq_pkg::OFF_SCRATCH)) begin
			rd_word = scratch;
		end
	end

	// read data is captured in the setup phase, giving zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (ce && psel && !penable) begin
			prdata <= rd_word;
		end
	end

	assign stack_top_upper = tos[20:16];
	assign stack_top_high = tos[15:8];
	assign stack_top_low = tos[7:0];
	assign stack_pointer = stack_pointer_reg.ptr;

	a_por_flags_load: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && por_active) |=> (reset_cause_reg == rsq_pkg::CAUSE_ON_POR &&
		stack_pointer_reg == rsq_pkg::STACK_ON_POR && core_reset))
		else $error("power-on did not load default flags");

	a_core_held_delay: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st == ST_DELAY && !delay_done) |=> core_reset)
		else $error("core released while timer counts");

	a_pin_release_run: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && st == ST_HOLD_PIN && external_reset_pin_n && !supply_low)
		|=> (!core_reset && st == ST_RUN))
		else $error("pin release did not start core");

	a_wdog_run_flag: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && wdog_rst) |=> (!reset_cause_reg.watchdog_expiry_flag &&
		core_reset && pc_load && pc_value == rsq_pkg::RESET_VECTOR))
		else $error("watchdog reset wrong");

	a_irq_vector_load: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && irq_take) |=> (pc_load && pc_value == ($past(irq_high_priority)
		? rsq_pkg::HIGH_VECTOR : rsq_pkg::LOW_VECTOR)))
		else $error("interrupt vector not loaded");

	a_irq_stack_push: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && irq_take) |=> (tos == $past(current_pc) &&
		stack_pointer_reg.ptr == rsq_pkg::SP_W'($past(stack_pointer_reg.ptr)
		+ rsq_pkg::SP_W'(1))))
		else $error("interrupt wake did not push pc");

	a_unf_flag_set: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && unf_ev && !por_active) |=>
		(stack_pointer_reg.stack_underflow_flag &&
		core_reset == $past(stack_error_reset_enable)))
		else $error("underflow handling wrong");

	a_wdog_wake_resume: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && wdog_wake) |=> (!core_reset && pc_load &&
		pc_value == rsq_pkg::PC_W'($past(current_pc) + rsq_pkg::PC_STEP) &&
		!reset_cause_reg.watchdog_expiry_flag &&
		!reset_cause_reg.sleep_entry_flag))
		else $error("watchdog wake did not resume");
endmodule : rsq_top
`default_nettype wire

// >>> tb.sv
// self-checking testbench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic por_act = 1'h1;
	logic bo_act = 1'h0;
	logic pin_n = 1'h0;
	logic osc = 1'h0;
	logic hi_prio = 1'h0;
	// 0 wdt, 1 overflow, 2 underflow, 3 opcode, 4 sleep, 5 clrwdt, 6 irq
	logic [6:0] ev = 7'h00;
	rsq_pkg::rsq_mode_e mode = rsq_pkg::MODE_FULL;
	logic [20:0] cpc = 21'h001234;
	logic core_reset;
	logic pc_load;
	logic pin_out;
	logic pin_oe;
	logic [20:0] pc_value;
	logic [4:0] tos_u;
	logic [7:0] tos_h;
	logic [7:0] tos_l;
	logic [4:0] sp;
	logic [31:0] rd;
	logic err;
	logic [4:0] ec;
	logic saw = 1'h0;
	logic saw_ld = 1'h0;
	logic ce = 1'h1;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;

	always #5 pclk = ~pclk;
	// free-running slow oscillator, eight pclk periods
	always begin
		repeat (4) @(posedge pclk);
		osc <= ~osc;
	end
	always @(posedge pclk) begin
		if (core_reset === 1'h1)
			saw <= 1'h1;
		if (pc_load === 1'h1)
			saw_ld <= 1'h1;
	end

	// shortened delay keeps the run small: 8 ticks instead of 2048
	rsq_top #(.DELAY_WIDTH(3), .DELAY_TICKS(8)) u_dut (
		.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.por_active(por_act), .brownout_active(bo_act),
		.external_reset_pin_n(pin_n),
		.external_reset_pin_out(pin_out),
		.external_reset_pin_oe(pin_oe),
		.internal_slow_oscillator(osc),
		.watchdog_timer_expired(ev[0]), .stack_overflow(ev[1]),
		.stack_underflow(ev[2]), .reset_opcode(ev[3]),
		.sleep_exec(ev[4]), .clrwdt_exec(ev[5]), .irq_wake(ev[6]),
		.irq_high_priority(hi_prio), .power_mode(mode),
		.current_pc(cpc), .core_reset(core_reset), .pc_load(pc_load),
		.pc_value(pc_value), .stack_top_upper(tos_u),
		.stack_top_high(tos_h), .stack_top_low(tos_l),
		.stack_pointer(sp)
	);

	task automatic finish_test;
		if (n_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// only the bench timeout ends a wait that never gets an answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic rc(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rd & m, e);
	endtask : rc

	task automatic pulse(input int i);
		@(posedge pclk);
		saw <= 1'h0;
		saw_ld <= 1'h0;
		ev[i] <= 1'h1;
		@(posedge pclk);
		ev[i] <= 1'h0;
		repeat (4) @(posedge pclk);
	endtask : pulse

	task automatic pin_rst;
		@(posedge pclk);
		pin_n <= 1'h0;
		repeat (3) @(posedge pclk);
		pin_n <= 1'h1;
		repeat (4) @(posedge pclk);
	endtask : pin_rst

	task automatic tos_chk(input logic [20:0] e);
		chk(32'({tos_u, tos_h, tos_l}), 32'(e));
	endtask : tos_chk

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			finish_test;
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		ec = 5'h1C;
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		chk(32'(pc_value), 32'h0);
		rc(rsq_pkg::OFF_STACK, 32'hC0, 32'h0);
		// power-on pulse still high: timer must not move
		repeat (100) @(posedge pclk);
		rc(rsq_pkg::OFF_STATUS, 32'h00070003, 32'h2);
		por_act <= 1'h0;
		repeat (40) @(posedge pclk);
		rc(rsq_pkg::OFF_STATUS, 32'h3, 32'h2);
		repeat (80) @(posedge pclk);
		rc(rsq_pkg::OFF_STATUS, 32'h3, 32'h3);
		@(posedge pclk);
		pin_n <= 1'h1;
		@(posedge pclk);
		@(negedge pclk);
		chk(32'(core_reset), 32'h0);
		apb(1'h1, rsq_pkg::OFF_SCRATCH, 32'hA5A55A5A);
		pulse(0);
		ec[3] = 1'h0;
		chk(32'(saw), 32'h1);
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		pin_rst;
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		mode <= rsq_pkg::MODE_RUN_LP;
		pin_rst;
		ec[3] = 1'h1;
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		mode <= rsq_pkg::MODE_FULL;
		pulse(0);
		mode <= rsq_pkg::MODE_SLEEP;
		pin_rst;
		ec[2] = 1'h0;
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		pulse(5);
		pulse(0);
		ec[3] = 1'h0;
		chk(32'(saw), 32'h0);
		chk(32'(saw_ld), 32'h1);
		chk(32'(pc_value), 32'h1236);
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		rc(rsq_pkg::OFF_SCRATCH, 32'hFFFFFFFF, 32'hA5A55A5A);
		tos_chk(21'h0);
		// sleep instruction: timeout flag set, power-down flag cleared
		pulse(4);
		ec[3] = 1'h1;
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		pulse(5);
		ec[3] = 1'h1;
		apb(1'h1, rsq_pkg::OFF_CTRL, 32'h2);
		hi_prio <= 1'h1;
		mode <= rsq_pkg::MODE_IDLE;
		pulse(6);
		ec[2] = 1'h0;
		chk(32'(pc_value), 32'h8);
		tos_chk(21'h001234);
		chk(32'(sp), 32'h1);
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		apb(1'h1, rsq_pkg::OFF_CTRL, 32'h4);
		hi_prio <= 1'h0;
		cpc <= 21'h002000;
		pulse(6);
		chk(32'(pc_value), 32'h18);
		tos_chk(21'h002000);
		chk(32'(sp), 32'h2);
		apb(1'h1, rsq_pkg::OFF_CTRL, 32'h0);
		pulse(6);
		chk(32'(pc_value), 32'h2002);
		chk(32'(sp), 32'h2);
		mode <= rsq_pkg::MODE_FULL;
		apb(1'h1, rsq_pkg::OFF_CTRL, 32'h1);
		pulse(1);
		chk(32'(pc_value), 32'h0);
		rc(rsq_pkg::OFF_STACK, 32'hC0, 32'h80);
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		apb(1'h1, rsq_pkg::OFF_STACK, 32'h0);
		apb(1'h1, rsq_pkg::OFF_CTRL, 32'h0);
		pulse(2);
		chk(32'(saw), 32'h0);
		chk(32'(saw_ld), 32'h0);
		rc(rsq_pkg::OFF_STACK, 32'hC0, 32'h40);
		apb(1'h1, rsq_pkg::OFF_CTRL, 32'h1);
		pulse(2);
		chk(32'(saw), 32'h1);
		rc(rsq_pkg::OFF_SCRATCH, 32'hFFFFFFFF, 32'hA5A55A5A);
		// clock enable low: an overflow must leave no trace
		ce <= 1'h0;
		pulse(1);
		ce <= 1'h1;
		chk(32'(saw), 32'h0);
		rc(rsq_pkg::OFF_STACK, 32'hC0, 32'h40);
		apb(1'h0, 12'h018, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		chk(32'({pin_out, pin_oe}), 32'h0);
		// brown-out, then a second dip before the delay can run out
		bo_act <= 1'h1;
		repeat (10) @(posedge pclk);
		ec = {3'h7, ec[1], 1'h0};
		rc(rsq_pkg::OFF_CAUSE, 32'h1F, 32'(ec));
		bo_act <= 1'h0;
		repeat (40) @(posedge pclk);
		chk(32'(core_reset), 32'h1);
		bo_act <= 1'h1;
		repeat (5) @(posedge pclk);
		bo_act <= 1'h0;
		repeat (40) @(posedge pclk);
		chk(32'(core_reset), 32'h1);
		repeat (100) begin
			if (core_reset !== 1'h0)
				@(posedge pclk);
		end
		chk(32'(core_reset), 32'h0);
		finish_test;
	end
endmodule : tb
`default_nettype wire
